// ### app_side_model.sv
// application-side model issuing descriptors and data words
`timescale 1ns/1ns
module app_side_model (
   input  wire logic            clock,
   input  wire logic            reset_n,
   input  wire logic            go,
   input  wire logic [127:0]    hdr,
   input  wire logic [9:0]      nwords,
   input  wire logic            desc_ack,
   input  wire logic            transmit_wait_state,
   output logic                 desc_request,
   output logic [127:0]         desc_word,
   output tx_app_pkg::data_in_t data_in,
   output logic                 busy
);
   logic        open;
   logic        take;
   logic [9:0]  left;
   logic [63:0] seq;
   // data phase is open from the acknowledge cycle itself
   assign take = (desc_ack | open) & data_in.transmit_data_valid & ~transmit_wait_state;
   assign busy = desc_request | data_in.data_follows;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         desc_request <= 1'b0;
         desc_word    <= '0;
         data_in      <= '0;
         open         <= 1'b0;
         left         <= '0;
         seq          <= '0;
      end else if (go) begin
         desc_request <= 1'b1;
         desc_word    <= hdr;
         left         <= nwords;
         data_in      <= {{2{nwords != 10'h0}}, seq};
      end else begin
         if (desc_ack) begin
            desc_request <= 1'b0;
            desc_word    <= ~desc_word;
         end
         open <= (open | desc_ack) & ~(take & left == 10'h1);
         // word held unchanged until a cycle without wait state
         // no nullify pulse here, so follows and valid fall only after the last word
         if (take) begin
            seq     <= seq + 64'h1;
            left    <= left - 10'h1;
            data_in <= (left == 10'h1) ? {2'b00, ~data_in.word} : {2'b11, seq + 64'h1};
         end
      end
   end
endmodule

// ### tx_app_if.sv
// transmit application interface: descriptor and data handshakes, word buffer, credit vector
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module tx_app_if #(
   parameter int BUF_DEPTH = tx_app_pkg::BUF_DEPTH
) (
   input  wire logic                             clock,
   input  wire logic                             reset_n,
   input  wire logic                             desc_request,
   input  wire logic [tx_app_pkg::DESC_W-1:0]    desc_word,
   output logic                                  desc_ack,
   input  wire tx_app_pkg::data_in_t             data_in,
   output logic                                  transmit_wait_state,
   output logic [tx_app_pkg::CRED_W-1:0]         credit_vector,
   input  wire tx_app_pkg::credit_avail_t        credit_avail,
   input  wire tx_app_pkg::arb_t                 arb_elsewhere,
   input  wire logic                             link_ready,
   output logic [tx_app_pkg::DESC_W-1:0]         link_desc,
   output logic                                  link_desc_valid,
   output logic [tx_app_pkg::DATA_W-1:0]         link_word,
   output logic                                  link_word_valid,
   input  wire tx_app_pkg::reg_req_t             reg_req,
   output logic [31:0]                           reg_rdata
);

   typedef struct packed {
      logic [BUF_DEPTH-1:0][tx_app_pkg::DATA_W-1:0] mem;
      logic [tx_app_pkg::CNT_W-1:0]                 count;
      tx_app_pkg::send_state_t                      state;
      logic [tx_app_pkg::LEFT_W-1:0]                words_left;
      logic                                         hdr4;
      logic                                         hdr_stall;
      logic [1:0]                                   taken;
      logic [1:0]                                   div;
      tx_app_pkg::ctrl_t                            ctrl;
      logic                                         ack;
      logic                                         ws;
      logic [tx_app_pkg::CRED_W-1:0]                cred;
      logic [tx_app_pkg::DESC_W-1:0]                ldesc;
      logic                                         ldesc_valid;
      logic [tx_app_pkg::DATA_W-1:0]                lword;
      logic                                         lword_valid;
      logic [31:0]                                  rdata;
   } regs_t;

   regs_t q;
   regs_t n;

   // header credit types report only whether one packet fits
   function automatic logic [7:0] one_packet(input logic [7:0] amount);
      one_packet = (amount != 8'h00) ? 8'h01 : 8'h00;
   endfunction

   function automatic logic [11:0] one_packet_wide(input logic [11:0] amount);
      one_packet_wide = (amount != 12'h000) ? 12'h001 : 12'h000;
   endfunction

   // posted and completion data credit counts saturate at a full 4 KB payload
   function automatic logic [11:0] clamp_data(input logic [11:0] amount);
      clamp_data = (amount > tx_app_pkg::CRED_DATA_MAX) ? tx_app_pkg::CRED_DATA_MAX : amount;
   endfunction

   // 64-bit words of payload; a length field of zero means 1024 dwords
   function automatic logic [tx_app_pkg::LEFT_W-1:0] payload_words(input logic [tx_app_pkg::DESC_W-1:0] d);
      logic [10:0] dw;
      dw = {1'b0, d[tx_app_pkg::DESC_LEN_LSB +: tx_app_pkg::DESC_LEN_W]};
      if (dw == 11'h000) begin
         dw = 11'h400;
      end
      payload_words = tx_app_pkg::LEFT_W'((dw + 11'h001) >> 1);
   endfunction

   logic                         take;
   logic                         drain;
   logic                         arb_lost;
   logic                         open_next;
   logic [tx_app_pkg::CNT_W-1:0] kept;

   always_comb begin
      n             = q;
      n.ack         = 1'b0;
      n.ldesc_valid = 1'b0;
      n.lword_valid = 1'b0;
      n.hdr_stall   = 1'b0;
      n.rdata       = 32'h0000_0000;

      // register port
      if (reg_req.wr && reg_req.addr == tx_app_pkg::REG_CTRL) begin
         n.ctrl = tx_app_pkg::ctrl_t'(reg_req.wdata[tx_app_pkg::CTRL_W-1:0]);
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            tx_app_pkg::REG_CTRL: begin
               n.rdata = {25'h0000000, q.ctrl};
            end
            tx_app_pkg::REG_STATUS: begin
               n.rdata = {16'h0000, q.words_left, q.ws, q.hdr4, q.state, q.count};
            end
            tx_app_pkg::REG_CREDIT: begin
               n.rdata = q.cred[31:0];
            end
            default: begin
               n.rdata = 32'h0000_0000;
            end
         endcase
      end

      // divider paces the link side when fewer lanes are trained
      n.div = (q.div == tx_app_pkg::NARROW_CLOCKS_LAST) ? 2'h0 : q.div + 2'h1;

      // no abort path: a taken packet always runs to its last word
      // words count only after the acknowledge opened the data phase
      // a held word is taken only when the wait state is low
      take = data_in.transmit_data_valid && data_in.data_follows && !q.ws
             && q.state == tx_app_pkg::ST_DATA && q.words_left != '0;

      // narrow link drains once per four clocks, so a full buffer throttles
      drain = (q.count != '0) && link_ready
              && (!q.ctrl.narrow_lanes || q.div == tx_app_pkg::NARROW_CLOCKS_LAST);

      if (drain) begin
         n.lword       = q.mem[0];
         n.lword_valid = 1'b1;
      end

      // three-entry word buffer, oldest word at index 0
      for (int i = 0; i < BUF_DEPTH - 1; i++) begin
         if (drain) begin
            n.mem[i] = q.mem[i+1];
         end
      end
      kept = q.count - tx_app_pkg::CNT_W'(drain);
      if (take) begin
         n.mem[kept] = data_in.word;
      end
      n.count = kept + tx_app_pkg::CNT_W'(take);

      if (take) begin
         n.words_left = q.words_left - tx_app_pkg::LEFT_W'(1);
         if (q.taken != 2'h3) begin
            n.taken = q.taken + 2'h1;
         end
      end

      // the first two phases pass free, then one stall for the long header
      // so back-to-back packets start at full rate
      if (take && q.hdr4 && n.taken == tx_app_pkg::HDR4_FREE_WORDS) begin
         n.hdr_stall = 1'b1;
         n.hdr4      = 1'b0;
      end

      unique case (q.state)
         tx_app_pkg::ST_IDLE: begin
            // a new descriptor waits until the previous packet has left
            // the descriptor side never looks at the data side's wait state
            if (desc_request && !q.ack) begin
               n.ack         = 1'b1;
               n.ldesc       = desc_word;
               n.ldesc_valid = 1'b1;
               n.taken       = 2'h0;
               if (desc_word[tx_app_pkg::DESC_DATA_BIT]) begin
                  // data phase opens in the acknowledge cycle itself
                  n.state      = tx_app_pkg::ST_DATA;
                  n.words_left = payload_words(desc_word);
                  n.hdr4       = desc_word[tx_app_pkg::DESC_4DW_BIT];
               end
            end
         end
         tx_app_pkg::ST_DATA: begin
            if (n.words_left == '0) begin
               n.state = tx_app_pkg::ST_FLUSH;
            end
         end
         tx_app_pkg::ST_FLUSH: begin
            // packet counts as sent only once its last word has gone to the link
            if (n.count == '0) begin
               n.state = tx_app_pkg::ST_IDLE;
            end
         end
         default: begin
            n.state = tx_app_pkg::ST_IDLE;
         end
      endcase

      // arbitration lost to another source stalls this channel
      arb_lost  = arb_elsewhere.link_packet || arb_elsewhere.config_completion
                  || arb_elsewhere.other_channel;
      open_next = (n.state == tx_app_pkg::ST_DATA) && (n.words_left != '0);
      // wait state when no phase is open, the buffer is full, the header stall fires or arbitration is lost
      n.ws = !open_next || (n.count >= tx_app_pkg::CNT_W'(BUF_DEPTH)) || n.hdr_stall || arb_lost;

      // credit vector, 66 bits: one-packet flags for headers and non-posted data, clamped posted/completion data, six infinite bits
      n.cred = '0;
      n.cred[tx_app_pkg::CRED_PH_LSB +: 8]    = one_packet(credit_avail.ph);
      n.cred[tx_app_pkg::CRED_PD_LSB +: 12]   = clamp_data(credit_avail.pd);
      n.cred[tx_app_pkg::CRED_NPH_LSB +: 8]   = one_packet(credit_avail.nph);
      n.cred[tx_app_pkg::CRED_NPD_LSB +: 12]  = one_packet_wide(credit_avail.npd);
      n.cred[tx_app_pkg::CRED_CPLH_LSB +: 8]  = one_packet(credit_avail.cplh);
      n.cred[tx_app_pkg::CRED_CPLD_LSB +: 12] = clamp_data(credit_avail.cpld);
      n.cred[tx_app_pkg::CRED_PH_INF]   = q.ctrl.inf_ph;
      n.cred[tx_app_pkg::CRED_PD_INF]   = q.ctrl.inf_pd;
      n.cred[tx_app_pkg::CRED_NPH_INF]  = q.ctrl.inf_nph;
      n.cred[tx_app_pkg::CRED_NPD_INF]  = q.ctrl.inf_npd;
      n.cred[tx_app_pkg::CRED_CPLH_INF] = q.ctrl.inf_cplh;
      n.cred[tx_app_pkg::CRED_CPLD_INF] = q.ctrl.inf_cpld;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q       <= '0;
         q.state <= tx_app_pkg::ST_IDLE;
         q.ctrl  <= tx_app_pkg::ctrl_t'(tx_app_pkg::CTRL_RESET);
         // wait state up until a packet opens
         q.ws    <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign desc_ack            = q.ack;
   assign transmit_wait_state = q.ws;
   assign credit_vector       = q.cred;
   assign link_desc           = q.ldesc;
   assign link_desc_valid     = q.ldesc_valid;
   assign link_word           = q.lword;
   assign link_word_valid     = q.lword_valid;
   assign reg_rdata           = q.rdata;

endmodule

// ### tx_app_if_monitor.sv
// port-level assertions for the transmit application interface
`timescale 1ns/1ns
module tx_app_if_monitor (
   input wire logic                          clock,
   input wire logic                          reset_n,
   input wire logic                          desc_ack,
   input wire logic                          link_desc_valid,
   input wire logic                          transmit_wait_state,
   input wire logic [tx_app_pkg::CRED_W-1:0] credit_vector,
   input wire tx_app_pkg::credit_avail_t     credit_avail,
   input wire tx_app_pkg::arb_t              arb_elsewhere,
   input wire logic                          link_ready,
   input wire logic                          link_word_valid,
   input wire tx_app_pkg::reg_req_t          reg_req,
   input wire logic [31:0]                   reg_rdata
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // $past(reset_n) keeps the first edge after release out of reach
   property p_ph;
      $past(reset_n) |-> credit_vector[7:0] == {7'h00, |$past(credit_avail.ph)};
   endproperty
   a_ph: assert property (p_ph) else $error("posted header credit wrong");
   property p_npd;
      $past(reset_n) |-> credit_vector[39:28] == {11'h000, |$past(credit_avail.npd)};
   endproperty
   a_npd: assert property (p_npd) else $error("non-posted data credit wrong");
   property p_cplh;
      $past(reset_n) |-> credit_vector[47:40] == {7'h00, |$past(credit_avail.cplh)};
   endproperty
   a_cplh: assert property (p_cplh) else $error("completion header credit wrong");
   property p_cpld;
      $past(reset_n) |-> credit_vector[59:48] ==
         (($past(credit_avail.cpld) > 12'h100) ? 12'h100 : $past(credit_avail.cpld));
   endproperty
   a_cpld: assert property (p_cpld) else $error("completion data count wrong");
   property p_arb;
      |arb_elsewhere |=> transmit_wait_state;
   endproperty
   a_arb: assert property (p_arb) else $error("no wait state while arbitration lost");
   property p_ack_pulse;
      desc_ack |=> !desc_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("descriptor acknowledge too long");
   property p_desc_fwd;
      desc_ack |-> link_desc_valid;
   endproperty
   a_desc_fwd: assert property (p_desc_fwd) else $error("descriptor not forwarded");
   property p_drain;
      link_word_valid |-> $past(link_ready);
   endproperty
   a_drain: assert property (p_drain) else $error("word drained while link not ready");
   property p_rdata;
      $past(reset_n) && !$past(reg_req.rd) |-> reg_rdata == 32'h0;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule

bind tx_app_if tx_app_if_monitor u_tx_app_if_monitor (.clock, .reset_n, .desc_ack, .link_desc_valid,
   .transmit_wait_state, .credit_vector, .credit_avail, .arb_elsewhere, .link_ready, .link_word_valid,
   .reg_req, .reg_rdata);

// ### tx_app_if_tb.sv
// self-checking bench for the transmit application interface
`timescale 1ns/1ns
module tx_app_if_tb;
   logic clock, reset_n, go, link_ready, busy, desc_request, desc_ack, transmit_wait_state;
   logic link_desc_valid, link_word_valid;
   logic [127:0] desc_word, link_desc, hdr;
   logic [63:0]  link_word, exp_word;
   logic [65:0]  credit_vector;
   logic [31:0]  reg_rdata;
   logic [9:0]   nwords;
   tx_app_pkg::data_in_t      data_in;
   tx_app_pkg::credit_avail_t credit_avail;
   tx_app_pkg::arb_t          arb_elsewhere;
   tx_app_pkg::reg_req_t      reg_req;
   int mismatches, checked, cyc, now_t, last_t, gap;
   tx_app_if u_tx_app_if (.clock, .reset_n, .desc_request, .desc_word, .desc_ack, .data_in, .transmit_wait_state,
      .credit_vector, .credit_avail, .arb_elsewhere, .link_ready, .link_desc, .link_desc_valid, .link_word,
      .link_word_valid, .reg_req, .reg_rdata);
   app_side_model u_app_side_model (.clock, .reset_n, .go, .hdr, .nwords, .desc_ack, .transmit_wait_state,
      .desc_request, .desc_word, .data_in, .busy);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_req <= {a, d, 2'b10};
      @(posedge clock);
      reg_req <= '0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_req <= {a, 32'h0, 2'b01};
      @(posedge clock);
      reg_req <= '0;
      #1 check(reg_rdata, exp);
   endtask
   // exp_cyc of zero skips the timing checks where stalls are expected
   task automatic send(input int n, input logic f, input int exp_cyc);
      @(posedge clock);
      // has-data bit only when words follow, else the design waits for words forever
      hdr <= {1'b0, n != 0, f, 19'h0, 10'(2 * n), 96'h0};
      nwords <= 10'(n);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      for (cyc = 0; !desc_ack && cyc < 400; cyc++) begin
         @(posedge clock);
         #1;
      end
      if (exp_cyc > 0) check(transmit_wait_state, 1'b0);
      for (cyc = 0; busy && cyc < 400; cyc++) begin
         @(posedge clock);
         #1;
      end
      if (exp_cyc > 0) check(cyc, exp_cyc);
   endtask
   always @(negedge clock) begin
      now_t++;
      if (link_word_valid) begin
         check(link_word, exp_word);
         exp_word++;
         gap = now_t - last_t;
         last_t = now_t;
      end
      if (link_desc_valid) check(link_desc, hdr);
   end
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      report_and_stop;
   end
   initial begin
      reset_n = 1'b0; go = 1'b0; hdr = '0; nwords = '0; link_ready = 1'b1;
      credit_avail = '0; arb_elsewhere = '0; reg_req = '0; exp_word = '0;
      mismatches = 0; checked = 0; now_t = 0; last_t = 0; gap = 0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      credit_avail <= {8'h05, 12'h3ff, 8'h00, 12'h002, 8'h00, 12'h0ff};
      repeat (3) @(posedge clock);
      #1 check(credit_vector[59:0], {12'h0ff, 8'h00, 12'h001, 8'h00, 12'h100, 8'h01});
      reg_rd(tx_app_pkg::REG_CREDIT, 32'h1001_0001);
      for (int i = 0; i < 6; i++) begin
         reg_wr(tx_app_pkg::REG_CTRL, 32'h2 << i);
         repeat (2) @(posedge clock);
         #1 check(credit_vector[65:60], 6'h1 << i);
      end
      reg_wr(4'hc, 32'hffff_ffff);
      reg_rd(4'hc, 32'h0);
      reg_rd(tx_app_pkg::REG_CTRL, 32'h40);
      reg_wr(tx_app_pkg::REG_CTRL, 32'h0);
      send(4, 1'b1, 5);
      send(3, 1'b0, 3);
      send(0, 1'b0, 0);
      // lost arbitration holds the wait state while the link is stalled, so no word enters the buffer
      @(posedge clock);
      link_ready <= 1'b0;
      arb_elsewhere <= 3'b111;
      fork
         send(6, 1'b0, 0);
         begin
            repeat (8) @(posedge clock);
            link_ready <= 1'b1;
            arb_elsewhere <= '0;
         end
      join
      reg_wr(tx_app_pkg::REG_CTRL, 32'h1);
      send(8, 1'b0, 0);
      repeat (40) @(posedge clock);
      check(gap, 4);
      check(exp_word, 64'h15);
      // idle: no phase open, so only the wait-state bit of the status word is set
      reg_rd(tx_app_pkg::REG_STATUS, 32'h0000_0020);
      report_and_stop;
   end
endmodule

// ### tx_app_pkg.sv
// shared constants and types for the transmit application interface
package tx_app_pkg;

   localparam int DATA_W    = 64;
   localparam int DESC_W    = 128;
   localparam int BUF_DEPTH = 3;
   localparam int CRED_W    = 66;
   localparam int CNT_W     = 2;
   localparam int LEFT_W    = 10;
   localparam int CTRL_W    = 7;

   // register offsets on the plain register port
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CREDIT = 4'h8;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

   // credit vector field positions
   localparam int CRED_PH_LSB   = 0;
   localparam int CRED_PD_LSB   = 8;
   localparam int CRED_NPH_LSB  = 20;
   localparam int CRED_NPD_LSB  = 28;
   localparam int CRED_CPLH_LSB = 40;
   localparam int CRED_CPLD_LSB = 48;
   localparam int CRED_PH_INF   = 60;
   localparam int CRED_PD_INF   = 61;
   localparam int CRED_NPH_INF  = 62;
   localparam int CRED_NPD_INF  = 63;
   localparam int CRED_CPLH_INF = 64;
   localparam int CRED_CPLD_INF = 65;
   localparam logic [11:0] CRED_DATA_MAX = 12'h100;

   // descriptor header fields (byte 0 of the header in bits 127:120)
   localparam int DESC_4DW_BIT  = 125;
   localparam int DESC_DATA_BIT = 126;
   localparam int DESC_LEN_LSB  = 96;
   localparam int DESC_LEN_W    = 10;

   // narrow link: last divider count, one data word every four clocks once the buffer fills
   localparam logic [1:0] NARROW_CLOCKS_LAST = 2'h3;
   // data phases taken before the four-dword header stall
   localparam logic [1:0] HDR4_FREE_WORDS = 2'h2;

   typedef struct packed {
      logic [7:0]  ph;
      logic [11:0] pd;
      logic [7:0]  nph;
      logic [11:0] npd;
      logic [7:0]  cplh;
      logic [11:0] cpld;
   } credit_avail_t;

   typedef struct packed {
      logic              data_follows;
      logic              transmit_data_valid;
      logic [DATA_W-1:0] word;
   } data_in_t;

   typedef struct packed {
      logic link_packet;
      logic config_completion;
      logic other_channel;
   } arb_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic inf_cpld;
      logic inf_cplh;
      logic inf_npd;
      logic inf_nph;
      logic inf_pd;
      logic inf_ph;
      logic narrow_lanes;
   } ctrl_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DATA,
      ST_FLUSH
   } send_state_t;

endpackage
